// *** logic/bus_status_led_indicator.v ***
`timescale 1ns/10ps
`include "led_indicator_defines.vh"

// Summary of operation
// - The module lamp stays dark when the interface module is absent, unpowered, not ready or is only an IO extension.
// - Running cyclic exchange lights the module lamp steady green and sets status bit 1.
// - An initialised module without cyclic exchange blinks green at 2 Hz and sets status bit 0.
// - An external bus timeout gives one 0.25 s red flash every 2.5 s and sets bit 2.
// - A monitor-time, switch, control-word timeout or hardware fault gives two red flashes per 2.5 s and sets bit 3.
// - A chip access failure, bus warning or system error blinks red at 2 Hz and sets bit 4.
// - A configuration error or bus off holds the module lamp steady red and sets bit 5.
// - The system-bus green lamp is dark without process data and blinks at 4 Hz on a bus warning.
// - The green lamp stays steady while at least one telegram arrives in every one-second interval.
// - Service data transfers are never counted as activity for the green lamp.
// - The red error lamp is dark with no error and blinks at 4 Hz on a telegram or bus monitor timeout.
// - The red error lamp blinks at 1 Hz on an external bus timeout or external module fault.
// - The red error lamp is steady while the controller is in bus off.
module bus_status_led_indicator #(
  parameter integer CLK_HZ = `CLK_HZ,
  parameter integer MS_CYC = `MS_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output wire ack_o,
  output wire err_o,
  // interface module condition flags (asynchronous pins)
  input wire module_fitted_i,
  input wire module_io_only_i,
  input wire control_voltage_ok_i,
  input wire module_ready_i,
  input wire module_init_i,
  input wire cyclic_exchange_i,
  input wire ext_bus_timeout_i,
  input wire monitor_timeout_i,
  input wire switch_error_i,
  input wire control_word_timeout_i,
  input wire hw_fault_i,
  input wire chip_access_fail_i,
  input wire module_bus_warning_i,
  input wire bus_system_error_i,
  input wire config_error_i,
  input wire module_bus_off_i,
  // system bus controller flags, same clock domain
  input wire pd_telegram_i,
  input wire sdo_telegram_i,
  input wire sysbus_warning_i,
  input wire telegram_timeout_error_i,
  input wire bus_monitor_error_i,
  input wire external_bus_timeout_error_i,
  input wire external_module_fault_error_i,
  input wire sysbus_off_i,
  // lamps
  output reg module_red_o,
  output reg module_green_o,
  output reg sysbus_green_o,
  output reg sysbus_red_o,
  output reg [`MSW_WIDTH-1:0] module_status_word_o
);
  // ****************************************
  // timing constants
  // ****************************************
  localparam integer HALF_2HZ = `HALF_2HZ_MS * MS_CYC;
  localparam integer HALF_4HZ = `HALF_4HZ_MS * MS_CYC;
  localparam integer HALF_1HZ = `HALF_1HZ_MS * MS_CYC;
  localparam integer FLASH_CYC = `FLASH_MS * MS_CYC;
  localparam integer PERIOD_CYC = `FLASH_PERIOD_MS * MS_CYC;
  localparam integer WIN_CYC = `ACT_WINDOW_MS * MS_CYC;
  localparam integer CW = 28;
  localparam integer NSYNC = 16;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // msb first, the decode below depends on this order
  wire [NSYNC-1:0] pins_w = {
    module_fitted_i,
    module_io_only_i,
    control_voltage_ok_i,
    module_ready_i,
    module_init_i,
    cyclic_exchange_i,
    ext_bus_timeout_i,
    monitor_timeout_i,
    switch_error_i,
    control_word_timeout_i,
    hw_fault_i,
    chip_access_fail_i,
    module_bus_warning_i,
    bus_system_error_i,
    config_error_i,
    module_bus_off_i
  };
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************
  // condition decode
  // ****************************************
  // several pins share one pattern, so they are merged after the sync;
  // a glitch on one pin can at worst add a single cycle of that pattern
  wire fitted_s = sync2_r[15];
  wire io_only_s = sync2_r[14];
  wire volt_s = sync2_r[13];
  wire ready_s = sync2_r[12];
  wire init_s = sync2_r[11];
  wire cyclic_s = sync2_r[10];
  wire ext_tmo_s = sync2_r[9];
  wire mon_tmo_s = sync2_r[8] | sync2_r[7] | sync2_r[6] | sync2_r[5];
  wire warn_s = sync2_r[4] | sync2_r[3] | sync2_r[2];
  wire cfg_s = sync2_r[1] | sync2_r[0];

  // ****************************************
  // blink sources
  // ****************************************
  wire wave_2hz;
  wire wave_4hz;
  wire wave_1hz;

  blink_divider #(.HALF_CYCLES(HALF_2HZ), .CNT_W(CW)) u_div_2hz (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wave_o(wave_2hz)
  );

  blink_divider #(.HALF_CYCLES(HALF_4HZ), .CNT_W(CW)) u_div_4hz (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wave_o(wave_4hz)
  );

  blink_divider #(.HALF_CYCLES(HALF_1HZ), .CNT_W(CW)) u_div_1hz (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wave_o(wave_1hz)
  );

  // flash frame: lamp lit in slot 0 (and slot 2 for double) of 0.25 s slots
  localparam integer FLASH_CYC2 = 2 * FLASH_CYC;
  localparam integer FLASH_CYC3 = 3 * FLASH_CYC;
  reg [CW-1:0] frame_cnt_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      frame_cnt_r <= {CW{1'b0}};
    end else if (frame_cnt_r == PERIOD_CYC[CW-1:0] - 1'b1) begin
      frame_cnt_r <= {CW{1'b0}};
    end else begin
      frame_cnt_r <= frame_cnt_r + 1'b1;
    end
  end

  wire flash1 = (frame_cnt_r < FLASH_CYC[CW-1:0]);
  wire flash2 = flash1 |
    ((frame_cnt_r >= FLASH_CYC2[CW-1:0]) && (frame_cnt_r < FLASH_CYC3[CW-1:0]));

  // ****************************************
  // process data activity window
  // ****************************************
  // a telegram in the current or the last completed window keeps the lamp on,
  // so a lamp never drops while the gap stays under one second
  reg [CW-1:0] win_cnt_r;
  reg seen_cur_r;
  reg seen_prev_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      win_cnt_r <= {CW{1'b0}};
      seen_cur_r <= 1'b0;
      seen_prev_r <= 1'b0;
    end else if (win_cnt_r == WIN_CYC[CW-1:0] - 1'b1) begin
      win_cnt_r <= {CW{1'b0}};
      seen_prev_r <= seen_cur_r | pd_telegram_i;
      seen_cur_r <= 1'b0;
    end else begin
      win_cnt_r <= win_cnt_r + 1'b1;
      if (pd_telegram_i) begin
        seen_cur_r <= 1'b1;
      end
    end
  end

  wire pd_active = seen_cur_r | seen_prev_r;

  // ****************************************
  // registers
  // ****************************************
  reg [31:0] ctl_r;
  reg ack_r;
  wire req_w = cyc_i & stb_i;
  wire hit_w = (adr_i == `ADDR_CONTROL) || (adr_i == `ADDR_STATUS) ||
    (adr_i == `ADDR_LAMPS);
  wire override_w = ctl_r[`CTL_OVERRIDE_BIT];
  wire lamp_test_w = ctl_r[`CTL_LAMP_TEST_BIT];
  integer i;

  // ****************************************
  // module lamp pattern selection
  // ****************************************
  // status bits follow the conditions live, not sticky, so there is no
  // set against clear race for software to resolve
  reg [2:0] mod_pat_nxt;
  reg [`MSW_WIDTH-1:0] msw_nxt;

  always @* begin
    msw_nxt = {`MSW_WIDTH{1'b0}};
    msw_nxt[`MSW_INIT_BIT] = init_s & ~cyclic_s;
    msw_nxt[`MSW_CYCLIC_BIT] = cyclic_s;
    msw_nxt[`MSW_EXT_TMO_BIT] = ext_tmo_s;
    msw_nxt[`MSW_MON_TMO_BIT] = mon_tmo_s;
    msw_nxt[`MSW_WARN_BIT] = warn_s;
    msw_nxt[`MSW_CFG_ERR_BIT] = cfg_s;
    if (!fitted_s || io_only_s || !volt_s || !ready_s) begin
      mod_pat_nxt = `PAT_OFF;
      msw_nxt = {`MSW_WIDTH{1'b0}};
    end else if (cfg_s) begin
      mod_pat_nxt = `PAT_ON;
    end else if (warn_s) begin
      mod_pat_nxt = `PAT_BLINK2;
    end else if (mon_tmo_s) begin
      mod_pat_nxt = `PAT_FLASH2;
    end else if (ext_tmo_s) begin
      mod_pat_nxt = `PAT_FLASH1;
    end else if (cyclic_s) begin
      mod_pat_nxt = `PAT_ON;
    end else if (init_s) begin
      mod_pat_nxt = `PAT_BLINK2;
    end else begin
      mod_pat_nxt = `PAT_OFF;
    end
  end

  wire mod_red_w = cfg_s | warn_s | mon_tmo_s | ext_tmo_s;

  // ****************************************
  // lamp outputs
  // ****************************************
  reg mod_lit;

  always @* begin
    case (mod_pat_nxt)
      `PAT_ON: mod_lit = 1'b1;
      `PAT_BLINK2: mod_lit = wave_2hz;
      `PAT_FLASH1: mod_lit = flash1;
      `PAT_FLASH2: mod_lit = flash2;
      default: mod_lit = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      module_red_o <= 1'b0;
      module_green_o <= 1'b0;
      sysbus_green_o <= 1'b0;
      sysbus_red_o <= 1'b0;
      module_status_word_o <= {`MSW_WIDTH{1'b0}};
    end else if (lamp_test_w) begin
      // service only: lights both red lamps and the system-bus green lamp regardless of conditions, so a user
      // must clear it before the lamps mean anything again
      module_red_o <= 1'b1;
      module_green_o <= 1'b0;
      sysbus_green_o <= 1'b1;
      sysbus_red_o <= 1'b1;
      module_status_word_o <= msw_nxt;
    end else begin
      module_red_o <= mod_lit & mod_red_w;
      module_green_o <= mod_lit & ~mod_red_w;
      module_status_word_o <= msw_nxt;
      if (sysbus_warning_i) begin
        sysbus_green_o <= wave_4hz;
      end else begin
        sysbus_green_o <= pd_active;
      end
      if (sysbus_off_i) begin
        sysbus_red_o <= 1'b1;
      end else if (external_bus_timeout_error_i | external_module_fault_error_i) begin
        sysbus_red_o <= wave_1hz;
      end else if (telegram_timeout_error_i | bus_monitor_error_i) begin
        sysbus_red_o <= wave_4hz;
      end else begin
        sysbus_red_o <= 1'b0;
      end
      if (override_w) begin
        module_red_o <= 1'b0;
        module_green_o <= 1'b0;
        sysbus_green_o <= 1'b0;
        sysbus_red_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= `CTL_RESET_VAL;
      ack_r <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      // one wait state: ack for a single cycle, then low for one cycle, so a
      // request that is held is taken again on every second cycle
      ack_r <= req_w & ~ack_r;
      if (req_w && !ack_r && hit_w) begin
        if (we_i && adr_i == `ADDR_CONTROL) begin
          for (i = 0; i < 4; i = i + 1) begin
            if (sel_i[i]) begin
              ctl_r[i*8 +: 8] <= dat_i[i*8 +: 8];
            end
          end
        end
        if (adr_i == `ADDR_CONTROL) begin
          dat_o <= ctl_r;
        end else if (adr_i == `ADDR_STATUS) begin
          dat_o <= {26'h0, module_status_word_o};
        end else begin
          dat_o <= {28'h0000000, module_red_o, module_green_o, sysbus_green_o,
            sysbus_red_o};
        end
      end
    end
  end

  assign ack_o = ack_r & hit_w & req_w;
  assign err_o = ack_r & ~hit_w & req_w;
endmodule // bus_status_led_indicator

// *** inc/led_indicator_defines.vh ***
`ifndef LED_INDICATOR_DEFINES_VH
`define LED_INDICATOR_DEFINES_VH

// ****************************************
// clock and timing
// ****************************************
`define CLK_HZ 100000000
// half periods and other durations in ms, cycle counts derived from the clock rate
`define HALF_2HZ_MS 250
`define HALF_4HZ_MS 125
`define HALF_1HZ_MS 500
`define FLASH_MS 250
`define FLASH_PERIOD_MS 2500
`define ACT_WINDOW_MS 1000
`define MS_CYCLES (`CLK_HZ / 1000)

// ****************************************
// wishbone register map (byte addresses)
// ****************************************
`define ADDR_CONTROL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_LAMPS 8'h08

// control register fields
`define CTL_OVERRIDE_BIT 0
`define CTL_LAMP_TEST_BIT 1
`define CTL_RESET_VAL 32'h00000000

// module status word bits
`define MSW_INIT_BIT 0
`define MSW_CYCLIC_BIT 1
`define MSW_EXT_TMO_BIT 2
`define MSW_MON_TMO_BIT 3
`define MSW_WARN_BIT 4
`define MSW_CFG_ERR_BIT 5
`define MSW_WIDTH 6

// lamp pattern codes
`define PAT_OFF 3'h0
`define PAT_ON 3'h1
`define PAT_SLOW 3'h2
`define PAT_FAST 3'h3
`define PAT_BLINK2 3'h4
`define PAT_FLASH1 3'h5
`define PAT_FLASH2 3'h6

`endif

// *** logic/blink_divider.v ***
`timescale 1ns/10ps
`include "led_indicator_defines.vh"

// square wave toggling every HALF_CYCLES clocks, phase restarts on reset
module blink_divider #(
  parameter integer HALF_CYCLES = 25000000,
  parameter integer CNT_W = 28
) (
  input wire clk_i,
  input wire rst_i,
  output wire wave_o
);
  reg [CNT_W-1:0] cnt_r;
  reg wave_r;

  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= {CNT_W{1'b0}};
      wave_r <= 1'b1;
    end else if (cnt_r == HALF_CYCLES[CNT_W-1:0] - 1'b1) begin
      cnt_r <= {CNT_W{1'b0}};
      wave_r <= ~wave_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign wave_o = wave_r;
endmodule // blink_divider

// *** tb/lamp_observer.sv ***
`timescale 1ns/10ps
// ******
// operator view: lit time and turn-on count per lamp
// ******
module lamp_observer (
  input wire clk_i,
  input wire clr_i,
  input wire [3:0] lamp_i,
  output logic [63:0] lit_o,
  output logic [31:0] rise_o
);
  logic [3:0] prev_r;
  always @(posedge clk_i) begin
    prev_r <= lamp_i;
    for (int i = 0; i < 4; i++) begin
      if (clr_i) begin
        lit_o[i*16 +: 16] <= 16'h0;
        rise_o[i*8 +: 8] <= 8'h0;
      end else begin
        lit_o[i*16 +: 16] <= lit_o[i*16 +: 16] + 16'(lamp_i[i]);
        rise_o[i*8 +: 8] <= rise_o[i*8 +: 8] + 8'(lamp_i[i] & ~prev_r[i]);
      end
    end
  end
endmodule // lamp_observer

// *** tb/led_monitor.sv ***
`timescale 1ns/10ps
`include "led_indicator_defines.vh"
module led_monitor #(
  parameter integer MS_CYC = `MS_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire module_fitted_i,
  input wire module_io_only_i,
  input wire control_voltage_ok_i,
  input wire module_ready_i,
  input wire module_init_i,
  input wire cyclic_exchange_i,
  input wire ext_bus_timeout_i,
  input wire monitor_timeout_i,
  input wire config_error_i,
  input wire pd_telegram_i,
  input wire sysbus_warning_i,
  input wire sysbus_off_i,
  input wire module_red_o,
  input wire module_green_o,
  input wire sysbus_green_o,
  input wire sysbus_red_o,
  input wire [`MSW_WIDTH-1:0] module_status_word_o
);
  localparam int IDLE = 2 * `ACT_WINDOW_MS * MS_CYC + 2;
  wire live = module_fitted_i && !module_io_only_i && control_voltage_ok_i && module_ready_i;
  logic [31:0] idle_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ******
  // helpers
  // ******
  // saturates, a telegram lights the lamp for two windows at most
  always @(posedge clk_i) begin
    if (rst_i || pd_telegram_i) begin
      idle_r <= 32'h0;
    end else if (idle_r <= IDLE) begin
      idle_r <= idle_r + 32'h1;
    end
  end
  // ******
  // properties
  // ******
  // pins pass a two-stage sync, four samples cover the lag
  property p_dark; (!live) [*4] |-> !module_red_o && !module_green_o && module_status_word_o == 6'h00;
  endproperty
  a_dark: assert property (p_dark) else $error("module lamp not dark");
  property p_cyc; (live && cyclic_exchange_i) [*4] |-> module_status_word_o[1];
  endproperty
  a_cyc: assert property (p_cyc) else $error("cyclic bit low");
  property p_init; (live && module_init_i && !cyclic_exchange_i) [*4] |-> module_status_word_o[0];
  endproperty
  a_init: assert property (p_init) else $error("init bit low");
  property p_ext; (live && ext_bus_timeout_i) [*4] |-> module_status_word_o[2];
  endproperty
  a_ext: assert property (p_ext) else $error("timeout bit low");
  property p_mon; (live && monitor_timeout_i) [*4] |-> module_status_word_o[3];
  endproperty
  a_mon: assert property (p_mon) else $error("monitor bit low");
  property p_cfg; (live && config_error_i) [*4] |-> module_red_o && !module_green_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config red not steady");
  property p_off; sysbus_off_i [*2] |-> sysbus_red_o;
  endproperty
  a_off: assert property (p_off) else $error("bus off lamp dark");
  property p_idle; idle_r > IDLE && !sysbus_warning_i && !$past(sysbus_warning_i) |-> !sysbus_green_o;
  endproperty
  a_idle: assert property (p_idle) else $error("green lit without telegrams");
  c_flash: cover property ((live && ext_bus_timeout_i) [*4]);
  c_off: cover property (sysbus_off_i && sysbus_red_o);
  c_idle: cover property (idle_r > IDLE);
endmodule // led_monitor

// *** tb/bus_status_led_indicator_bench.sv ***
`timescale 1ns/10ps
`include "led_indicator_defines.vh"
module bus_status_led_indicator_bench;
  localparam int MS = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0, pd = 1'b0, sdo = 1'b0;
  logic [7:0] adr = 8'h0, s = 8'h0;
  logic [3:0] sel = 4'h0, lamp;
  logic [31:0] wd = 32'h0, rd, rise;
  logic [15:0] p = 16'h0;
  logic [11:0] tick = 12'h0;
  logic [5:0] msw;
  logic [63:0] lit;
  logic ack, err;
  int n_mismatch = 0;
  int n_compared = 0;
  always #5 clk_i = ~clk_i;
  // telegram every 1000 cycles, well inside one activity window
  always @(posedge clk_i) begin
    tick <= (tick == 12'd999) ? 12'h0 : tick + 12'h1;
    pd <= s[0] && tick == 12'h0;
    sdo <= s[1] && tick == 12'd500;
  end
  bus_status_led_indicator #(.MS_CYC(MS)) dut (
    .clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wd), .dat_o(rd), .ack_o(ack), .err_o(err),
    .module_fitted_i(p[0]), .module_io_only_i(p[1]), .control_voltage_ok_i(p[2]),
    .module_ready_i(p[3]), .module_init_i(p[4]), .cyclic_exchange_i(p[5]),
    .ext_bus_timeout_i(p[6]), .monitor_timeout_i(p[7]), .switch_error_i(p[8]),
    .control_word_timeout_i(p[9]), .hw_fault_i(p[10]), .chip_access_fail_i(p[11]),
    .module_bus_warning_i(p[12]), .bus_system_error_i(p[13]), .config_error_i(p[14]),
    .module_bus_off_i(p[15]), .pd_telegram_i(pd), .sdo_telegram_i(sdo),
    .sysbus_warning_i(s[2]), .telegram_timeout_error_i(s[3]), .bus_monitor_error_i(s[4]),
    .external_bus_timeout_error_i(s[5]), .external_module_fault_error_i(s[6]),
    .sysbus_off_i(s[7]), .module_red_o(lamp[3]), .module_green_o(lamp[2]),
    .sysbus_green_o(lamp[1]), .sysbus_red_o(lamp[0]), .module_status_word_o(msw));
  lamp_observer eye (.clk_i, .clr_i(clr), .lamp_i(lamp), .lit_o(lit), .rise_o(rise));
  // ******
  // tasks
  // ******
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] exp, input logic ex_err);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
    {cyc, stb, we} <= 3'b000;
    check({31'h0, k < 20}, 32'h1);
    check({31'h0, err}, {31'h0, ex_err});
    if (!w && !ex_err) check(rd, exp);
  endtask
  // codes: 0 dark, 1 steady, 2/4/5 blink 2/4/1 Hz, d double flash, f single flash
  function automatic void expect_of(input logic [3:0] c, input int n,
                                    output logic [15:0] l, output logic [7:0] r);
    int h;
    h = c == 4'h2 ? `HALF_2HZ_MS * MS : c == 4'h4 ? `HALF_4HZ_MS * MS : `HALF_1HZ_MS * MS;
    l = 16'(c == 4'h1 ? n : c == 4'h0 ? 0 : n / 2);
    r = (c < 4'h2) ? 8'h0 : 8'(n / (2 * h));
    if (c > 4'hc) begin
      r = 8'((c == 4'hd ? 2 : 1) * (n / (`FLASH_PERIOD_MS * MS)));
      l = 16'(r * `FLASH_MS * MS);
    end
  endfunction
  // windows are whole periods, so counts do not depend on phase
  task automatic run(input logic [15:0] pv, input logic [7:0] sv, input int settle,
                     input int n, input logic [5:0] mw, input logic [15:0] pat);
    logic [15:0] el;
    logic [7:0] er;
    @(posedge clk_i);
    p <= pv;
    s <= sv;
    repeat (settle) @(posedge clk_i);
    check({26'h0, msw}, {26'h0, mw});
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
    for (int i = 0; i < 4; i++) begin
      expect_of(pat[i*4 +: 4], n, el, er);
      check({16'h0, lit[i*16 +: 16]}, {16'h0, el});
      check({24'h0, rise[i*8 +: 8]}, {24'h0, er});
    end
  endtask
  // ******
  // sequence
  // ******
  initial begin
    #1000000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `ADDR_STATUS, 32'h0, 32'h0, 1'b0);
    wb(1'b1, `ADDR_CONTROL, 32'h1, 32'h0, 1'b0);
    wb(1'b0, `ADDR_CONTROL, 32'h0, 32'h1, 1'b0);
    wb(1'b1, `ADDR_CONTROL, `CTL_RESET_VAL, 32'h0, 1'b0);
    wb(1'b1, `ADDR_STATUS, 32'h3f, 32'h0, 1'b0);
    wb(1'b0, `ADDR_STATUS, 32'h0, 32'h0, 1'b0);
    wb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
    run(16'h0020, 8'h02, 10, 5000, 6'h00, 16'h0000);
    run(16'h002f, 8'h00, 10, 100, 6'h00, 16'h0000);
    run(16'h0029, 8'h00, 10, 100, 6'h00, 16'h0000);
    run(16'h002d, 8'h01, 1010, 5000, 6'h02, 16'h0110);
    wb(1'b0, `ADDR_STATUS, 32'h0, 32'h2, 1'b0);
    wb(1'b0, `ADDR_LAMPS, 32'h0, 32'h6, 1'b0);
    run(16'h001d, 8'h00, 4010, 5000, 6'h01, 16'h0200);
    run(16'h004d, 8'h04, 10, 5000, 6'h04, 16'hf040);
    run(16'h008d, 8'h08, 10, 5000, 6'h08, 16'hd004);
    run(16'h010d, 8'h10, 10, 5000, 6'h08, 16'hd004);
    run(16'h020d, 8'h00, 10, 0, 6'h08, 16'h0000);
    run(16'h040d, 8'h00, 10, 0, 6'h08, 16'h0000);
    run(16'h080d, 8'h20, 10, 4000, 6'h10, 16'h2005);
    run(16'h100d, 8'h00, 10, 0, 6'h10, 16'h0000);
    run(16'h200d, 8'h40, 10, 4000, 6'h10, 16'h2005);
    run(16'h400d, 8'h00, 10, 1000, 6'h20, 16'h1000);
    run(16'h800d, 8'ha8, 10, 1000, 6'h20, 16'h1001);
    run(16'h40fd, 8'h0d, 10, 1000, 6'h2e, 16'h1044);
    run(16'h088d, 8'h00, 4010, 1000, 6'h18, 16'h2000);
    end_sim();
  end
endmodule // bus_status_led_indicator_bench
bind bus_status_led_indicator led_monitor #(.MS_CYC(MS_CYC)) mon_u (
  .clk_i, .rst_i, .module_fitted_i, .module_io_only_i, .control_voltage_ok_i, .module_ready_i,
  .module_init_i, .cyclic_exchange_i, .ext_bus_timeout_i, .monitor_timeout_i, .config_error_i,
  .pd_telegram_i, .sysbus_warning_i, .sysbus_off_i, .module_red_o, .module_green_o,
  .sysbus_green_o, .sysbus_red_o, .module_status_word_o);
